// ===== pkg/ara_pkg.sv
// constants, field layouts and carriers for the drive register access engine
package ara_pkg;

   // ---------------------------------------------------------------
   // microcontroller register map
   // ---------------------------------------------------------------
   localparam logic [15:0] ADDR_DATA_LOW  = 16'hF0D2;
   localparam logic [15:0] ADDR_DATA_HIGH = 16'hF0D3;
   localparam logic [15:0] ADDR_CONTROL   = 16'hF0D4;

   // control register field positions
   localparam int CTL_SECT_MSB_BIT = 0;
   localparam int CTL_CLEAR_BIT    = 1;
   localparam int CTL_READ_BIT     = 2;
   localparam int CTL_WRITE_BIT    = 3;
   localparam int CTL_ADR_LSB      = 4;
   localparam int CTL_ADR_MSB      = 7;

   // reset values
   localparam logic [15:0] HOLD_RESET     = 16'h0000;
   localparam logic [3:0]  ADR_RESET      = 4'h0;
   localparam logic [8:0]  SECT_CNT_RESET = 9'h000;
   localparam logic [7:0]  RDATA_RESET    = 8'h00;

   // drive address decode
   localparam int          ADR_BLOCK_BIT = 3;
   localparam logic [3:0]  ADR_DATA_REG  = 4'h8;

   // ---------------------------------------------------------------
   // register cycle timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   localparam int T_SETUP_NS    = 70;
   localparam int T_STROBE_NS   = 290;
   localparam int T_HOLD_NS     = 30;
   localparam int T_CYCLE_NS    = 600;
   localparam int SYNC_STAGES   = 2;

   localparam int SETUP_CYC_I  = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STROBE_CYC_I = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_CYC_I   = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CYCLE_CYC_I  = (T_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETUP_CYC    = (SETUP_CYC_I < 1) ? 1 : SETUP_CYC_I;
   localparam int STROBE_CYC   = ((STROBE_CYC_I < 1) ? 1 : STROBE_CYC_I) + SYNC_STAGES;
   localparam int HOLD_MIN     = (HOLD_CYC_I < 1) ? 1 : HOLD_CYC_I;
   localparam int HOLD_FILL    = CYCLE_CYC_I - SETUP_CYC - STROBE_CYC;
   localparam int HOLD_CYC     = (HOLD_FILL > HOLD_MIN) ? HOLD_FILL : HOLD_MIN;

   localparam logic [2:0] SETUP_LOAD  = 3'(SETUP_CYC - 1);
   localparam logic [2:0] STROBE_LOAD = 3'(STROBE_CYC - 1);
   localparam logic [2:0] HOLD_LOAD   = 3'(HOLD_CYC - 1);

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      ARA_IDLE   = 2'b00,
      ARA_SETUP  = 2'b01,
      ARA_STROBE = 2'b10,
      ARA_HOLD   = 2'b11
   } ara_state_t;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
   } ara_mcu_req_t;

   typedef struct packed {
      logic        cs0_n;
      logic        cs1_n;
      logic [2:0]  da;
      logic        dior_n;
      logic        diow_n;
      logic [15:0] dd_out;
      logic [15:0] dd_oe;
   } ara_ata_out_t;

   localparam ara_ata_out_t ATA_IDLE_PINS = '{cs0_n: 1'b1, cs1_n: 1'b1, da: 3'h0, dior_n: 1'b1,
                                             diow_n: 1'b1, dd_out: 16'h0000, dd_oe: 16'h0000};

endpackage

// ===== src/ara_sync.sv
// two-stage synchroniser for pin inputs
module ara_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             sys_rst,
   // asynchronous input and synchronised output
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;
   logic [WIDTH-1:0] nxt_meta;
   logic [WIDTH-1:0] nxt_sync;

   always_comb begin
      nxt_meta = async_in;
      nxt_sync = meta_ff;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= nxt_meta;
         sync_ff <= nxt_sync;
      end
   end

   assign sync_out = sync_ff;

endmodule

// ===== src/ara_top.sv
// drive register access engine: single programmed register cycles on the parallel drive bus
module ara_top (
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  sys_rst,
   // microcontroller register port
   input  wire ara_pkg::ara_mcu_req_t mcu_req,
   output logic [7:0]                 mcu_rdata,
   // sector counter and fifo control
   input  wire logic                  sect_cnt_load,
   input  wire logic [8:0]            sect_cnt_init,
   input  wire logic                  sector_done,
   output logic [8:0]                 sector_counter,
   output logic                       sector_buffer_clear,
   // drive bus pins
   input  wire logic [15:0]           dd_in,
   input  wire logic                  iordy,
   output ara_pkg::ara_ata_out_t      ata_out
);
   import ara_pkg::*;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic [15:0]  access_holding_word_ff;
   logic [15:0]  nxt_access_holding_word;
   logic [3:0]   drive_reg_address_ff;
   logic [3:0]   nxt_drive_reg_address;
   logic         bus_read_request_ff;
   logic         nxt_bus_read_request;
   logic         bus_write_request_ff;
   logic         nxt_bus_write_request;
   logic         sector_buffer_clear_ff;
   logic         nxt_sector_buffer_clear;
   logic [8:0]   sector_counter_ff;
   logic [8:0]   nxt_sector_counter;
   logic [7:0]   rdata_ff;
   logic [7:0]   nxt_rdata;
   ara_state_t   state_ff;
   ara_state_t   nxt_state;
   logic [2:0]   cnt_ff;
   logic [2:0]   nxt_cnt;
   logic         is_read_ff;
   logic         nxt_is_read;
   ara_ata_out_t pins_ff;
   ara_ata_out_t nxt_pins;

   logic [16:0]  pin_sync;
   logic [15:0]  dd_sync;
   logic         iordy_sync;
   logic         engine_idle;
   logic         wide_access;
   logic [7:0]   control_view;

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   ara_sync #(
      .WIDTH(17)
   ) u_pin_sync (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .async_in ({iordy, dd_in}),
      .sync_out (pin_sync)
   );

   assign dd_sync    = pin_sync[15:0];
   assign iordy_sync = pin_sync[16];

   // ---------------------------------------------------------------
   // decode helpers
   // ---------------------------------------------------------------
   assign engine_idle = (state_ff == ARA_IDLE) && !bus_read_request_ff && !bus_write_request_ff;
   assign wide_access = (drive_reg_address_ff == ADR_DATA_REG);

   always_comb begin
      control_view                               = 8'h00;
      control_view[CTL_ADR_MSB:CTL_ADR_LSB]      = drive_reg_address_ff;
      control_view[CTL_WRITE_BIT]                = bus_write_request_ff;
      control_view[CTL_READ_BIT]                 = bus_read_request_ff;
      control_view[CTL_CLEAR_BIT]                = sector_buffer_clear_ff;
      control_view[CTL_SECT_MSB_BIT]             = sector_counter_ff[8];
   end

   // ---------------------------------------------------------------
   // register file and cycle engine
   // ---------------------------------------------------------------
   always_comb begin
      nxt_access_holding_word = access_holding_word_ff;
      nxt_drive_reg_address   = drive_reg_address_ff;
      nxt_bus_read_request    = bus_read_request_ff;
      nxt_bus_write_request   = bus_write_request_ff;
      nxt_sector_buffer_clear = 1'b0;
      nxt_state               = state_ff;
      nxt_cnt                 = cnt_ff;
      nxt_is_read             = is_read_ff;

      // cycle engine; completion first, and held-field firmware writes in the same cycle are dropped since the engine is not yet idle
      unique case (state_ff)
         ARA_IDLE: begin
            if (bus_read_request_ff || bus_write_request_ff) begin
               nxt_state   = ARA_SETUP;
               nxt_cnt     = SETUP_LOAD;
               nxt_is_read = bus_read_request_ff;
            end
         end
         ARA_SETUP: begin
            if (cnt_ff == 3'h0) begin
               nxt_state = ARA_STROBE;
               nxt_cnt   = STROBE_LOAD;
            end else begin
               nxt_cnt = cnt_ff - 3'h1;
            end
         end
         ARA_STROBE: begin
            // strobe stretched by the synchroniser depth so sampled data is from inside the strobe
            if (cnt_ff != 3'h0) begin
               nxt_cnt = cnt_ff - 3'h1;
            end else if (iordy_sync) begin
               nxt_state = ARA_HOLD;
               nxt_cnt   = HOLD_LOAD;
               if (is_read_ff) begin
                  if (wide_access) begin
                     nxt_access_holding_word = dd_sync;
                  end else begin
                     nxt_access_holding_word[7:0] = dd_sync[7:0];
                  end
               end
            end
         end
         ARA_HOLD: begin
            if (cnt_ff == 3'h0) begin
               nxt_state             = ARA_IDLE;
               nxt_bus_read_request  = 1'b0;
               nxt_bus_write_request = 1'b0;
            end else begin
               nxt_cnt = cnt_ff - 3'h1;
            end
         end
      endcase

      // firmware writes; firmware changes held fields only while no cycle is pending
      if (mcu_req.wr) begin
         unique case (mcu_req.addr)
            ADDR_DATA_LOW: begin
               if (engine_idle) begin
                  nxt_access_holding_word[7:0] = mcu_req.wdata;
               end
            end
            ADDR_DATA_HIGH: begin
               if (engine_idle) begin
                  nxt_access_holding_word[15:8] = mcu_req.wdata;
               end
            end
            ADDR_CONTROL: begin
               if (mcu_req.wdata[CTL_CLEAR_BIT]) begin
                  nxt_sector_buffer_clear = 1'b1;
               end
               if (engine_idle) begin
                  nxt_drive_reg_address = mcu_req.wdata[CTL_ADR_MSB:CTL_ADR_LSB];
                  nxt_bus_read_request  = mcu_req.wdata[CTL_READ_BIT];
                  nxt_bus_write_request = mcu_req.wdata[CTL_WRITE_BIT];
               end
            end
            default: begin
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // sector counter
   // ---------------------------------------------------------------
   always_comb begin
      nxt_sector_counter = sector_counter_ff;
      // a load beats a decrement; the count stops at zero instead of wrapping
      if (sect_cnt_load) begin
         nxt_sector_counter = sect_cnt_init;
      end else if (sector_done && (sector_counter_ff != SECT_CNT_RESET)) begin
         nxt_sector_counter = sector_counter_ff - 9'h001;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sector_counter_ff <= SECT_CNT_RESET;
      end else begin
         sector_counter_ff <= nxt_sector_counter;
      end
   end

   // ---------------------------------------------------------------
   // firmware read data
   // ---------------------------------------------------------------
   always_comb begin
      nxt_rdata = rdata_ff;
      // answered one cycle after the strobe; unmapped addresses read zero
      if (mcu_req.rd) begin
         unique case (mcu_req.addr)
            ADDR_DATA_LOW:  nxt_rdata = access_holding_word_ff[7:0];
            ADDR_DATA_HIGH: nxt_rdata = access_holding_word_ff[15:8];
            ADDR_CONTROL:   nxt_rdata = control_view;
            default:        nxt_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdata_ff <= RDATA_RESET;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   // ---------------------------------------------------------------
   // drive bus pins, registered from the next state
   // ---------------------------------------------------------------
   always_comb begin
      nxt_pins = ATA_IDLE_PINS;
      if (nxt_state != ARA_IDLE) begin
         // no address is refused; reserved offsets run like any other
         nxt_pins.da = nxt_drive_reg_address[2:0];
         if (nxt_drive_reg_address[ADR_BLOCK_BIT]) begin
            nxt_pins.cs0_n = 1'b0;
         end else begin
            nxt_pins.cs1_n = 1'b0;
         end
         if (!nxt_is_read) begin
            nxt_pins.dd_out = nxt_access_holding_word;
            nxt_pins.dd_oe  = (nxt_drive_reg_address == ADR_DATA_REG) ? 16'hFFFF : 16'h00FF;
         end
         if (nxt_state == ARA_STROBE) begin
            nxt_pins.dior_n = !nxt_is_read;
            nxt_pins.diow_n = nxt_is_read;
         end
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         access_holding_word_ff <= HOLD_RESET;
         drive_reg_address_ff   <= ADR_RESET;
         bus_read_request_ff    <= 1'b0;
         bus_write_request_ff   <= 1'b0;
         sector_buffer_clear_ff <= 1'b0;
         state_ff               <= ARA_IDLE;
         cnt_ff                 <= 3'h0;
         is_read_ff             <= 1'b0;
      end else begin
         access_holding_word_ff <= nxt_access_holding_word;
         drive_reg_address_ff   <= nxt_drive_reg_address;
         bus_read_request_ff    <= nxt_bus_read_request;
         bus_write_request_ff   <= nxt_bus_write_request;
         sector_buffer_clear_ff <= nxt_sector_buffer_clear;
         state_ff               <= nxt_state;
         cnt_ff                 <= nxt_cnt;
         is_read_ff             <= nxt_is_read;
      end
   end

   // pins leave flip-flops directly so selects and strobes never glitch
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pins_ff <= ATA_IDLE_PINS;
      end else begin
         pins_ff <= nxt_pins;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign mcu_rdata           = rdata_ff;
   assign sector_counter      = sector_counter_ff;
   assign sector_buffer_clear = sector_buffer_clear_ff;
   assign ata_out             = pins_ff;

endmodule

// ===== test/ara_checker.sv
// port checks for the drive register access engine
module ara_checker (
   // clock and reset
   input wire logic                  clk,
   input wire logic                  sys_rst,
   // microcontroller side
   input wire ara_pkg::ara_mcu_req_t mcu_req,
   input wire logic [7:0]            mcu_rdata,
   // sector counter and fifo
   input wire logic                  sect_cnt_load,
   input wire logic [8:0]            sect_cnt_init,
   input wire logic                  sector_done,
   input wire logic [8:0]            sector_counter,
   input wire logic                  sector_buffer_clear,
   // drive bus
   input wire logic [15:0]           dd_in,
   input wire logic                  iordy,
   input wire ara_pkg::ara_ata_out_t ata_out
);
   timeunit 1ns;
   timeprecision 1ns;
   import ara_pkg::*;
   logic strb_off;
   logic ctl_wr;
   assign strb_off = ata_out.dior_n & ata_out.diow_n;
   assign ctl_wr   = mcu_req.wr & (mcu_req.addr == ADDR_CONTROL);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence s_strobe_low;
      (!strb_off) [*5];
   endsequence
   sequence s_hold_idle;
      $stable(ata_out.da) && $stable(ata_out.cs0_n) && $stable(ata_out.cs1_n) ##1 (ata_out.cs0_n && ata_out.cs1_n);
   endsequence
   a_one_select: assert property (!(ata_out.cs0_n == 1'b0 && ata_out.cs1_n == 1'b0))
      else $error("both selects low");
   a_strobe_select: assert property (!strb_off |-> ata_out.cs0_n != ata_out.cs1_n)
      else $error("strobe without one select");
   a_setup_first: assert property ($fell(strb_off) |-> $stable(ata_out.da) &&
      ($past(ata_out.cs0_n) == 1'b0 || $past(ata_out.cs1_n) == 1'b0)) else $error("no setup");
   a_strobe_width: assert property ($fell(strb_off) |-> s_strobe_low ##[1:30] strb_off)
      else $error("strobe width");
   a_hold_release: assert property ($rose(strb_off) |-> s_hold_idle)
      else $error("hold or release");
   a_write_width: assert property (!ata_out.diow_n |-> ata_out.dd_oe ==
      ((!ata_out.cs0_n && ata_out.da == 3'h0) ? 16'hFFFF : 16'h00FF)) else $error("write width");
   a_read_float: assert property (!ata_out.dior_n |-> ata_out.dd_oe == 16'h0000)
      else $error("driving during read");
   a_data_steady: assert property (!ata_out.diow_n && !$past(ata_out.diow_n) |-> $stable(ata_out.dd_out))
      else $error("write data moved");
   a_clear_pulse: assert property (ctl_wr && mcu_req.wdata[1] |-> ##[1:2] sector_buffer_clear)
      else $error("no clear pulse");
   a_clear_single: assert property (sector_buffer_clear |=> !sector_buffer_clear)
      else $error("clear pulse too long");
   a_count_load: assert property (sect_cnt_load |=> sector_counter == $past(sect_cnt_init))
      else $error("counter load");
   a_count_down: assert property (sector_done && !sect_cnt_load && sector_counter != 9'h000
      |=> sector_counter == $past(sector_counter) - 9'h001) else $error("counter step");
   a_msb_read: assert property (mcu_req.rd && mcu_req.addr == ADDR_CONTROL
      |=> mcu_rdata[0] == $past(sector_counter[8])) else $error("counter msb read");
endmodule

// ===== test/ara_drive_model.sv
// behavioural drive: sixteen bus registers, optional slow ready
module ara_drive_model (
   // clock and pace
   input  wire logic                  clk,
   input  wire logic                  slow,
   // bus pins
   input  wire ara_pkg::ara_ata_out_t pins,
   output logic [15:0]                dd_in,
   output logic                       iordy
);
   timeunit 1ns;
   timeprecision 1ns;
   import ara_pkg::*;
   logic [15:0] mem [16];
   logic [15:0] last = 16'h0000;
   logic [2:0]  wait_cnt = 3'h0;
   logic [3:0]  idx;
   // every address decodes alike, reserved ones too
   assign idx = {~pins.cs0_n, pins.da};
   always @(posedge clk) begin
      if (!pins.diow_n)
         mem[idx] <= (mem[idx] & ~pins.dd_oe) | (pins.dd_out & pins.dd_oe);
      if (!pins.dior_n)
         last <= dd_in;
      wait_cnt <= (pins.dior_n & pins.diow_n) ? 3'h0 : wait_cnt + 3'(wait_cnt != 3'h7);
   end
   // narrow registers leave the upper lines noisy; released lines show the inverse
   assign dd_in = !pins.dior_n ? ((idx == 4'h8) ? mem[idx] : {~mem[idx][7:0], mem[idx][7:0]}) : ~last;
   assign iordy = !(slow && wait_cnt < 3'h3);
endmodule

// ===== test/ara_top_test.sv
// self-checking bench for the drive register access engine
module ara_top_test;
   timeunit 1ns;
   timeprecision 1ns;
   import ara_pkg::*;
   typedef struct packed {
      logic [3:0]  a;
      logic [15:0] d;
      logic [15:0] e;
   } ara_row_t;
   logic         clk = 1'b0;
   logic         sys_rst = 1'b1;
   ara_mcu_req_t mcu_req = '0;
   logic [7:0]   mcu_rdata;
   logic         sect_cnt_load = 1'b0;
   logic [8:0]   sect_cnt_init = 9'h000;
   logic         sector_done = 1'b0;
   logic [8:0]   sector_counter;
   logic         sector_buffer_clear;
   logic [15:0]  dd_in;
   logic         iordy;
   ara_ata_out_t ata_out;
   logic         slow = 1'b0;
   ara_row_t     rows [16];
   logic [8:0]   exp_cnt [6] = '{9'h101, 9'h100, 9'h0FF, 9'h001, 9'h000, 9'h000};
   int           bad_count = 0;
   int           n_checks = 0;
   int           n_wstb = 0;
   int           rd_low = 0;
   logic [4:0]   seen;
   logic [7:0]   rv;
   logic [15:0]  hw;
   logic [1:0]   pulses;
   always #50 clk = ~clk;
   ara_top uut (.clk(clk), .sys_rst(sys_rst), .mcu_req(mcu_req), .mcu_rdata(mcu_rdata),
      .sect_cnt_load(sect_cnt_load), .sect_cnt_init(sect_cnt_init), .sector_done(sector_done),
      .sector_counter(sector_counter), .sector_buffer_clear(sector_buffer_clear),
      .dd_in(dd_in), .iordy(iordy), .ata_out(ata_out));
   ara_drive_model drv (.clk(clk), .slow(slow), .pins(ata_out), .dd_in(dd_in), .iordy(iordy));
   always @(posedge clk) begin
      if (!ata_out.diow_n)
         n_wstb++;
      if (!ata_out.dior_n) begin
         rd_low++;
         seen = {ata_out.cs1_n, ata_out.cs0_n, ata_out.da};
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
      mcu_req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(negedge clk);
      mcu_req.wr = 1'b0;
      @(negedge clk);
   endtask
   task automatic reg_rd(input logic [15:0] a, output logic [7:0] d);
      mcu_req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(negedge clk);
      mcu_req.rd = 1'b0;
      @(negedge clk);
      d = mcu_rdata;
   endtask
   task automatic set_word(input logic [15:0] w);
      reg_wr(ADDR_DATA_LOW, w[7:0]);
      reg_wr(ADDR_DATA_HIGH, w[15:8]);
   endtask
   task automatic get_word(output logic [15:0] w);
      logic [7:0] lo;
      logic [7:0] hi;
      reg_rd(ADDR_DATA_LOW, lo);
      reg_rd(ADDR_DATA_HIGH, hi);
      w = {hi, lo};
   endtask
   task automatic poll;
      for (int i = 0; i < 40; i++) begin
         reg_rd(ADDR_CONTROL, rv);
         if (rv[3:2] == 2'b00)
            return;
      end
      chk(16'h0001, 16'h0000);
   endtask
   task automatic run(input logic [3:0] a, input logic [3:0] bits);
      reg_wr(ADDR_CONTROL, {a, bits});
      poll;
   endtask
   task automatic final_report;
      if (bad_count == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #3000000;
      bad_count++;
      final_report;
   end
   initial begin
      foreach (rows[i]) begin
         rows[i].a = 4'(i);
         rows[i].d = 16'hA5C3 ^ {4{4'(i)}};
         rows[i].e = (i == 8) ? rows[i].d : {~rows[i].d[15:8], rows[i].d[7:0]};
      end
      repeat (20) @(negedge clk);
      sys_rst = 1'b0;
      chk(16'(ata_out == ATA_IDLE_PINS), 16'h0001);
      for (int i = 0; i < 4; i++) begin
         reg_rd(ADDR_DATA_LOW + 16'(i), rv);
         chk({8'h00, rv}, 16'h0000);
      end
      reg_wr(ADDR_CONTROL, 8'hA0);
      reg_rd(ADDR_CONTROL, rv);
      chk({8'h00, rv}, 16'h00A0);
      set_word(16'h3C5A);
      get_word(hw);
      chk(hw, 16'h3C5A);
      foreach (rows[i]) begin
         set_word(rows[i].d);
         run(rows[i].a, 4'h8);
         set_word(~rows[i].d);
         run(rows[i].a, 4'h4);
         get_word(hw);
         chk(hw, rows[i].e);
         chk({11'h000, seen}, {11'h000, rows[i].a[3], ~rows[i].a[3], rows[i].a[2:0]});
      end
      // read and write requested together
      set_word(16'h5A5A);
      n_wstb = 0;
      reg_wr(ADDR_CONTROL, 8'h8C);
      reg_rd(ADDR_CONTROL, rv);
      chk({14'h0000, rv[3:2]}, 16'h0003);
      poll;
      get_word(hw);
      chk(hw, rows[8].d);
      chk(16'(n_wstb), 16'h0000);
      // drive holds ready low at the start of the strobe
      slow = 1'b1;
      rd_low = 0;
      run(4'h7, 4'h4);
      slow = 1'b0;
      get_word(hw);
      chk(hw, {rows[8].d[15:8], rows[7].d[7:0]});
      chk(16'(rd_low > 5), 16'h0001);
      mcu_req = '{addr: ADDR_CONTROL, wdata: 8'h02, wr: 1'b1, rd: 1'b0};
      @(negedge clk);
      mcu_req.wr = 1'b0;
      pulses = 2'(sector_buffer_clear);
      repeat (2) begin
         @(negedge clk);
         pulses = pulses + 2'(sector_buffer_clear);
      end
      chk({14'h0000, pulses}, 16'h0001);
      for (int i = 0; i < 6; i++) begin
         sect_cnt_load = (i == 0 || i == 3);
         sect_cnt_init = (i == 0) ? 9'h101 : 9'h001;
         sector_done = (i != 0 && i != 3);
         @(negedge clk);
         sect_cnt_load = 1'b0;
         sector_done = 1'b0;
         reg_rd(ADDR_CONTROL, rv);
         chk({15'h0000, rv[0]}, {15'h0000, exp_cnt[i][8]});
         chk({7'h00, sector_counter}, {7'h00, exp_cnt[i]});
      end
      final_report;
   end
endmodule
bind ara_top ara_checker u_chk (.clk(clk), .sys_rst(sys_rst), .mcu_req(mcu_req), .mcu_rdata(mcu_rdata),
   .sect_cnt_load(sect_cnt_load), .sect_cnt_init(sect_cnt_init), .sector_done(sector_done),
   .sector_counter(sector_counter), .sector_buffer_clear(sector_buffer_clear),
   .dd_in(dd_in), .iordy(iordy), .ata_out(ata_out));
